//--- rtl/stat_regs_pkg.sv
package stat_regs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_OPMODE   = 8'h00;
  localparam logic [7:0] OFS_BUFFILL  = 8'h01;
  localparam logic [7:0] OFS_ACCCNT   = 8'h02;
  localparam logic [7:0] OFS_ALERTSRC = 8'h03;
  localparam logic [7:0] OFS_SEQ      = 8'h04;
  localparam logic [7:0] OFS_C0_LO    = 8'h08;
  localparam logic [7:0] OFS_C0_HI    = 8'h09;
  localparam logic [7:0] OFS_C1_LO    = 8'h0a;
  localparam logic [7:0] OFS_C1_HI    = 8'h0b;
  localparam logic [7:0] OFS_UNDER    = 8'h0c;
  localparam logic [7:0] OFS_OVER     = 8'h0e;
  localparam logic [7:0] OFS_SRST     = 8'h14;
  localparam logic [7:0] OFS_CAL      = 8'h15;
  localparam logic [7:0] OFS_KEY      = 8'h17;
  // ==========================================================
  // Field positions and values
  localparam int         FAST_BUS_BIT = 2;
  localparam int         SEQ_LSB      = 1;
  localparam int         CHID_LSB     = 4;
  localparam int         NUM_REGS     = 14;
  localparam logic [3:0] UNLOCK_KEY   = 4'ha;
  localparam logic [3:0] KEY_RESET    = 4'h0;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [1:0] MODE_MANUAL  = 2'h0;
  localparam logic [1:0] MODE_AUTO    = 2'h2;
  localparam logic [1:0] MODE_PREC    = 2'h3;
  localparam logic [1:0] SEQ_OFF      = 2'h0;
  localparam logic [1:0] SEQ_ON       = 2'h1;
  localparam logic [1:0] SEQ_ERR      = 2'h3;
  localparam logic [4:0] MAX_FILL     = 5'h10;
  // Bus operation codes of the register port
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_WRITE = 3'b010,
    OP_READ  = 3'b100
  } bus_op_t;
endpackage

//--- rtl/stat_byte_mux.sv
`timescale 1ns/1ps
// ==========================================================
// Registered read port: one byte per read strobe
module stat_byte_mux #(
  parameter int N = 14
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // Image of the register bytes
  input  wire logic [7:0]   bytes_i [N],
  input  wire logic [N-1:0] hit_i,
  input  wire logic         rd_i,
  // Read answer
  output logic      [7:0]   data_o
);
  logic [7:0] sel;

  // A mux with no inputs has nothing to answer with
  if (N < 1) begin : g_bad_n
    $error("byte mux needs at least one input");
  end

  // Or together the hit byte; no hit gives zero
  always_comb begin
    sel = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (hit_i[i]) begin
        sel = sel | bytes_i[i];
      end
    end
  end

  // Read data out of a register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_o <= 8'h00;
    end else if (rd_i) begin
      data_o <= sel;
    end
  end
endmodule

//--- rtl/adc_status_alert_register_bank.sv
`timescale 1ns/1ps
// Behaviour
// - Reserved bits read zero and ignore writes.
// - Bit 2 of mode status shows fast bus mode.
// - Mode field reports 00 manual, 10 autonomous, 11 precision; never 01.
// - Buffer status bits 4..0 give filled entries, 0 to 16.
// - Accumulation status bits 3..0 give completed accumulation count.
// - Alert source bits 7..4 hold first alerting channel id.
// - Sequencer field bits 2..1: 00 off, 01 on, 11 on with error.
// - Channel sums readable as low and high bytes at 0x8..0xb.
// - Under-limit flags at 0xc, one read-write bit per channel.
// - Over-limit flags at 0xe, one read-write bit per channel.
// - Writing 1 to bit 0 at 0x14 resets the device.
// - Reset write is granted only while key 1010 is held at 0x17.
// - Key field survives a device reset.
// - Writing 1 to bit 0 at 0x15 starts offset calibration.
// - Reads of unimplemented addresses return zero.
module adc_status_alert_register_bank (
  // Clock and power-on reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Register port from the serial front end
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // Device state from the core
  input  wire logic       fast_bus_active_i,
  input  wire logic [1:0] current_operating_state_i,
  input  wire logic [4:0] buffer_entry_count_i,
  input  wire logic [3:0] summation_count_i,
  input  wire logic [3:0] first_alert_channel_i,
  input  wire logic [1:0] sequencer_error_state_i,
  input  wire logic [15:0] chan0_sum_i,
  input  wire logic [15:0] chan1_sum_i,
  // Comparator alert events, one bit per channel
  input  wire logic [1:0] under_limit_event_i,
  input  wire logic [1:0] over_limit_event_i,
  // Outputs to the core
  output logic [1:0]      under_limit_flags_o,
  output logic [1:0]      over_limit_flags_o,
  output logic            soft_reset_o,
  output logic            offset_cal_start_o
);
  localparam int N = stat_regs_pkg::NUM_REGS;

  // Channels served by the flag bytes
  localparam int NUM_CHAN = 2;

  // Slots of the writable registers in the decoder's hit vector
  localparam int IDX_UNDER = 9;
  localparam int IDX_OVER  = 10;
  localparam int IDX_SRST  = 11;
  localparam int IDX_CAL   = 12;
  localparam int IDX_KEY   = 13;

  // Codes that the core should never present; each is folded on read
  localparam logic [1:0] MODE_UNUSED = 2'h1;
  localparam logic [1:0] SEQ_UNUSED  = 2'h2;

  // ==========================================================
  // Elaboration checks
  // The decoder names its registers one by one, so the map size is fixed
  if (N != 14) begin : g_map_size
    $error("register map size does not match the decoder");
  end
  // The flag ports carry exactly one bit per channel
  if (NUM_CHAN != 2) begin : g_chan_count
    $error("channel count does not match the flag ports");
  end

  // ==========================================================
  // Decode
  function automatic logic [N-1:0] decode(input logic [7:0] a);
    logic [N-1:0] h;
    h = '0;
    // Status registers
    h[0]  = (a == stat_regs_pkg::OFS_OPMODE);
    h[1]  = (a == stat_regs_pkg::OFS_BUFFILL);
    h[2]  = (a == stat_regs_pkg::OFS_ACCCNT);
    h[3]  = (a == stat_regs_pkg::OFS_ALERTSRC);
    h[4]  = (a == stat_regs_pkg::OFS_SEQ);
    // Channel sums
    h[5]  = (a == stat_regs_pkg::OFS_C0_LO);
    h[6]  = (a == stat_regs_pkg::OFS_C0_HI);
    h[7]  = (a == stat_regs_pkg::OFS_C1_LO);
    h[8]  = (a == stat_regs_pkg::OFS_C1_HI);
    // Alert flags
    h[9]  = (a == stat_regs_pkg::OFS_UNDER);
    h[10] = (a == stat_regs_pkg::OFS_OVER);
    // Triggers and key
    h[11] = (a == stat_regs_pkg::OFS_SRST);
    h[12] = (a == stat_regs_pkg::OFS_CAL);
    h[13] = (a == stat_regs_pkg::OFS_KEY);
    return h;
  endfunction

  // Registers and read image
  logic [N-1:0] hit;
  logic         key_ok;
  logic [3:0]   reset_unlock_key_r;
  logic [1:0]   under_r;
  logic [1:0]   over_r;
  logic         srst_r;
  logic         cal_r;
  logic         soft_reset_bit_n;
  logic [1:0]   mode_val;
  logic [4:0]   fill_val;
  logic [7:0]   bytes [N];
  logic [1:0]   seq_val;
  logic         wr_under;
  logic         wr_over;
  logic         wr_srst;
  logic         wr_cal;
  logic         wr_key;

  assign hit    = decode(addr_i);
  // Key match, used only to grant the soft reset
  assign key_ok = (reset_unlock_key_r == stat_regs_pkg::UNLOCK_KEY);

  // ==========================================================
  // Write strobes, one per writable register
  // Each process reads one plain name instead of indexing the hit vector
  assign wr_under = wr_i && hit[IDX_UNDER];
  assign wr_over  = wr_i && hit[IDX_OVER];
  assign wr_srst  = wr_i && hit[IDX_SRST];
  assign wr_cal   = wr_i && hit[IDX_CAL];
  assign wr_key   = wr_i && hit[IDX_KEY];

  // ==========================================================
  // Soft reset grant
  // A reset write counts only with the key in place and no pulse running;
  // a request during the pulse would otherwise stretch it past one cycle.
  // Without the key the write is simply dropped.
  function automatic logic reset_granted(input logic req,
                                         input logic ok,
                                         input logic busy);
    return req && ok && !busy;
  endfunction

  // Device-wide reset: power-on or a granted soft reset from the last cycle.
  // The soft reset is taken from a flop, not from the write strobe, so the
  // write that asks for it is finished before anything is cleared.
  // The key and the read port stay on power-on reset only: the key must
  // survive, and the host may still be reading the reply to its write.
  // Limitation: a soft reset restarts only what this block holds.
  assign soft_reset_bit_n = reset_n_i & ~srst_r;

  // ==========================================================
  // Key: only power-on clears it, never the soft reset.
  // Only the low nibble is stored; the upper bits have nowhere to go
  // and so read zero whatever the host sends.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reset_unlock_key_r <= stat_regs_pkg::KEY_RESET;
    end else if (wr_key) begin
      reset_unlock_key_r <= wdata_i[3:0]; // upper bits dropped
    end
  end

  // Soft reset pulse, one cycle, only with key present
  // The pulse itself restarts flags and triggers on the following edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= reset_granted(wr_srst && wdata_i[0], key_ok, srst_r);
    end
  end

  // Calibration start pulse
  // A soft reset in flight cancels a calibration request of the same cycle
  always_ff @(posedge clk_i) begin
    if (!soft_reset_bit_n) begin
      cal_r <= 1'b0;
    end else begin
      cal_r <= wr_cal && wdata_i[0];
    end
  end

  // ==========================================================
  // Alert flags, one cell per channel and per side
  // An event and a host clear may land in one cycle; the event wins,
  // so that an alert raised while the host clears is never lost.
  // The price: a flag fed by a standing event cannot be cleared by a host write.
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_flag
    // Under-limit cell of this channel
    always_ff @(posedge clk_i) begin
      if (!soft_reset_bit_n) begin
        under_r[c] <= 1'b0;
      end else if (wr_under) begin
        under_r[c] <= wdata_i[c] | under_limit_event_i[c];
      end else begin
        under_r[c] <= under_r[c] | under_limit_event_i[c];
      end
    end

    // Over-limit cell of this channel
    always_ff @(posedge clk_i) begin
      if (!soft_reset_bit_n) begin
        over_r[c] <= 1'b0;
      end else if (wr_over) begin
        over_r[c] <= wdata_i[c] | over_limit_event_i[c];
      end else begin
        over_r[c] <= over_r[c] | over_limit_event_i[c];
      end
    end
  end

  // Outputs straight from flops
  // No gate sits between a flop and a pin, so the core sees clean levels
  assign under_limit_flags_o = under_r;
  assign over_limit_flags_o  = over_r;
  assign soft_reset_o        = srst_r;
  assign offset_cal_start_o  = cal_r;

  // ==========================================================
  // Field folding
  // A state code that the map leaves unused reads as manual mode,
  // so the host never sees a code it cannot interpret
  function automatic logic [1:0] fold_mode(input logic [1:0] s);
    logic [1:0] m;
    m = s;
    if (s == MODE_UNUSED) begin
      m = stat_regs_pkg::MODE_MANUAL;
    end
    return m;
  endfunction

  // A fill count above a full buffer is clamped, never wrapped,
  // so a glitching counter cannot make a full buffer look empty
  function automatic logic [4:0] clamp_fill(input logic [4:0] n);
    logic [4:0] f;
    f = n;
    if (n > stat_regs_pkg::MAX_FILL) begin
      f = stat_regs_pkg::MAX_FILL;
    end
    return f;
  endfunction

  // An unused sequencer code reads as the error code: the host
  // then looks closer instead of trusting a silent sequencer
  function automatic logic [1:0] fold_seq(input logic [1:0] s);
    logic [1:0] q;
    q = s;
    if (s == SEQ_UNUSED) begin
      q = stat_regs_pkg::SEQ_ERR;
    end
    return q;
  endfunction

  // ==========================================================
  // Read image
  // Folded fields, recomputed every cycle from the core's levels
  assign mode_val = fold_mode(current_operating_state_i);
  assign fill_val = clamp_fill(buffer_entry_count_i);
  assign seq_val  = fold_seq(sequencer_error_state_i);

  // Byte image of the map; every slot starts from zero
  always_comb begin
    for (int i = 0; i < N; i++) begin
      bytes[i] = stat_regs_pkg::ZERO_BYTE;
    end
    // Mode byte: fast bus flag above the folded state
    bytes[0][stat_regs_pkg::FAST_BUS_BIT] = fast_bus_active_i;
    bytes[0][1:0] = mode_val;
    // Buffer fill and accumulation count, upper bits left zero
    bytes[1][4:0] = fill_val;
    bytes[2][3:0] = summation_count_i;
    // Channel of the first alert sits in the upper nibble
    bytes[3][stat_regs_pkg::CHID_LSB +: 4] = first_alert_channel_i;
    // Sequencer state sits one bit up; bit 0 stays zero
    bytes[4][stat_regs_pkg::SEQ_LSB +: 2] = seq_val;
    // Sums are read live: the two halves of one sum may come from
    // different instants while the core is still adding
    bytes[5] = chan0_sum_i[7:0];
    bytes[6] = chan0_sum_i[15:8];
    bytes[7] = chan1_sum_i[7:0];
    bytes[8] = chan1_sum_i[15:8];
    // Flag bytes and key nibble; the trigger slots stay zero
    bytes[9][1:0]  = under_r;
    bytes[10][1:0] = over_r;
    bytes[13][3:0] = reset_unlock_key_r;
  end

  // Unmapped addresses hit nothing and read zero.
  // The answer is registered and held until the next read strobe,
  // so a slow host may sample it late; it costs one cycle of latency.
  // The read port is not touched by the soft reset.
  stat_byte_mux #(.N(N)) u_mux (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .bytes_i   (bytes),
    .hit_i     (hit),
    .rd_i      (rd_i),
    .data_o    (rdata_o)
  );
endmodule

//--- verif/adc_status_alert_register_bank_checker.sv
`timescale 1ns/1ps
// ==========
// Port checks of the status bank
module adc_status_alert_register_bank_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Register port
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // State, events and pulses
  input wire logic       fast_bus_active_i,
  input wire logic [1:0] over_limit_event_i,
  input wire logic [1:0] over_limit_flags_o,
  input wire logic       soft_reset_o,
  input wire logic       offset_cal_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Key write, idle cycle, then reset write while no pulse is running
  sequence key_then_rst(bit ok);
    wr_i && addr_i == 8'h17 && ((wdata_i[3:0] == 4'ha) == ok) ##1 !wr_i
    ##1 wr_i && addr_i == 8'h14 && wdata_i[0] && !soft_reset_o;
  endsequence
  chk_key_grants_reset: assert property (key_then_rst(1'b1) |=> soft_reset_o)
    else $error("keyed reset write gave no pulse");
  chk_nokey_no_reset: assert property (key_then_rst(1'b0) |=> !soft_reset_o)
    else $error("reset pulse without key");
  chk_reset_one_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("reset pulse too long");
  chk_cal_start_pulse: assert property (wr_i && addr_i == 8'h15 && wdata_i[0] && !soft_reset_o
    |=> offset_cal_start_o ##1 !offset_cal_start_o) else $error("bad calibration pulse");
  chk_fast_bus_bit: assert property (rd_i && addr_i == 8'h00
    |=> rdata_o[2] == $past(fast_bus_active_i)) else $error("fast bus bit wrong");
  chk_mode_code_legal: assert property (rd_i && addr_i == 8'h00
    |=> rdata_o[1:0] != 2'h1 && rdata_o[7:3] == 5'h00) else $error("mode byte wrong");
  chk_trigger_reads_zero: assert property (rd_i && addr_i inside {8'h14, 8'h15}
    |=> rdata_o == 8'h00) else $error("trigger register not zero");
  chk_unmapped_reads_zero: assert property (rd_i && addr_i inside {8'h05, 8'h16, 8'h18}
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_over_flag_set: assert property (over_limit_event_i[1] && !soft_reset_o
    |=> over_limit_flags_o[1]) else $error("over flag not set by event");
  chk_over_flag_write: assert property (wr_i && addr_i == 8'h0e && !soft_reset_o
    |=> over_limit_flags_o == ($past(wdata_i[1:0]) | $past(over_limit_event_i)))
    else $error("over flag write wrong");
endmodule

bind adc_status_alert_register_bank adc_status_alert_register_bank_checker chk (
  .clk_i, .reset_n_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .fast_bus_active_i,
  .over_limit_event_i, .over_limit_flags_o, .soft_reset_o, .offset_cal_start_o);

//--- verif/host_model.sv
`timescale 1ns/1ps
// ==========
// Host side: one byte per strobe, address and data parked inverted
module host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  // Write; the key's upper nibble always goes out as zero
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = (a == 8'h17) ? {4'h0, d[3:0]} : d;
    @(posedge clk_i);
    #1;
    wr_o    = 1'b0;
    addr_o  = ~addr_o; // Never leave the last value standing
    wdata_o = ~wdata_o;
  endtask
  // Read; the answer stands from the taking edge on
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_o   = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o   = 1'b0;
    addr_o = ~addr_o;
    d      = rdata_i;
  endtask
endmodule

//--- verif/adc_status_alert_register_bank_test.sv
`timescale 1ns/1ps
module adc_status_alert_register_bank_test;
  // ==========
  // Stimulus and model state
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        wr_i, rd_i, fb, sr, cal;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [1:0]  md, sq, ul, ol, uf, of, ufo, ofo;
  logic [4:0]  bc;
  logic [3:0]  sc, fa;
  logic [15:0] s0, s1;
  logic [15:0] lfsr = 16'ha8de;
  int          err_count = 0;
  int          comparisons = 0;
  int          n_sr = 0, n_cal = 0, key = 0;
  always #2 clk_i = ~clk_i;
  host_model host (.clk_i, .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .rdata_i(rdata_o));
  adc_status_alert_register_bank DUT (.clk_i, .reset_n_i, .wr_i, .rd_i, .addr_i, .wdata_i,
    .rdata_o, .fast_bus_active_i(fb), .current_operating_state_i(md),
    .buffer_entry_count_i(bc), .summation_count_i(sc), .first_alert_channel_i(fa),
    .sequencer_error_state_i(sq), .chan0_sum_i(s0), .chan1_sum_i(s1),
    .under_limit_event_i(ul), .over_limit_event_i(ol), .under_limit_flags_o(ufo),
    .over_limit_flags_o(ofo), .soft_reset_o(sr), .offset_cal_start_o(cal));
  // Count pulses; a missed or doubled pulse shows in the totals
  always @(posedge clk_i) begin
    if (sr === 1'b1) n_sr++;
    if (cal === 1'b1) n_cal++;
  end
  function automatic logic [15:0] step(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected byte; unused mode and sequencer codes fold as the design chose
  function automatic logic [7:0] model_rd(logic [7:0] a);
    case (a)
      8'h00: return {5'h00, fb, (md == 2'h1) ? 2'h0 : md};
      8'h01: return {3'h0, (bc > 5'h10) ? 5'h10 : bc};
      8'h02: return {4'h0, sc};
      8'h03: return {fa, 4'h0};
      8'h04: return {5'h00, (sq == 2'h2) ? 2'h3 : sq, 1'b0};
      8'h08: return s0[7:0];
      8'h09: return s0[15:8];
      8'h0a: return s1[7:0];
      8'h0b: return s1[15:8];
      8'h0c: return {6'h00, uf};
      8'h0e: return {6'h00, of};
      8'h17: return 8'(key);
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
    end
  endtask
  // Read every address up to one past the key, mapped or not
  task automatic sweep;
    logic [7:0] d;
    for (int a = 0; a < 25; a++) begin
      host.get(8'(a), d);
      check("read", d, model_rd(8'(a)));
    end
  endtask
  task print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Random status, flag writes with events, then the keyed reset path
  initial begin
    {fb, md, sq, ul, ol, bc, sc, fa, s0, s1, uf, of} = '0;
    repeat (6) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    sweep();
    for (int r = 0; r < 6; r++) begin
      lfsr = step(lfsr);
      {fb, md, bc, sc, sq, fa[0]} = lfsr[14:0];
      s0 = step(lfsr);
      s1 = step(s0);
      host.put(8'h0c, {6'h00, lfsr[1:0]});
      uf = lfsr[1:0];
      host.put(8'h0e, {6'h00, lfsr[3:2]});
      of = lfsr[3:2];
      {ul, ol} = lfsr[7:4];
      @(posedge clk_i);
      #1;
      {ul, ol} = 4'h0;
      uf = uf | lfsr[7:6];
      of = of | lfsr[5:4];
      check("under flags", {6'h00, ufo}, {6'h00, uf});
      check("over flags", {6'h00, ofo}, {6'h00, of});
      sweep();
    end
    host.put(8'h17, 8'h05);
    host.put(8'h14, 8'h01);
    host.put(8'h17, 8'h0a);
    key = 10;
    check("unkeyed reset", 8'(n_sr), 8'h00);
    host.put(8'h14, 8'h01);
    {uf, of} = 4'h0;
    host.put(8'h15, 8'h01);
    @(posedge clk_i);
    #1;
    check("keyed reset", 8'(n_sr), 8'h01);
    check("calibration", 8'(n_cal), 8'h01);
    check("under flags", {6'h00, ufo}, 8'h00);
    check("over flags", {6'h00, ofo}, 8'h00);
    sweep();
    host.put(8'h17, 8'h00);
    key = 0;
    sweep();
    print_verdict();
  end
  // Watchdog well past the expected run of about five hundred cycles
  initial begin
    #40000;
    err_count++;
    print_verdict();
  end
endmodule
